// File: inc/two_wire_consts.vh
// constants for the two-wire controller: register map, fields, status codes
`ifndef TWO_WIRE_CONSTS_VH
`define TWO_WIRE_CONSTS_VH
// register indices, byte address is four times the index
`define IDX_RANGE   11:2
`define IDX_BRD     10'h070
`define IDX_STS     10'h071
`define IDX_ADR     10'h072
`define IDX_DAT     10'h073
`define IDX_CTL     10'h074
`define IDX_IST     10'h075
`define IDX_IMK     10'h076
`define HSIZE_WORD  3'h2
// reset values
`define RST_BRD     8'h00
`define RST_ADR     8'h7F
`define RST_DAT     8'hFF
// control register bit positions
`define C_JD        7
`define C_EA        6
`define C_STA       5
`define C_STO       4
`define C_WC        3
`define C_EN        2
`define C_IE        0
// status register fields
`define STS_CODE    7:3
`define STS_PS      1:0
// interrupt status and mask layout
`define IRQ_BITS    2:0
`define IRQ_JD      0
`define IRQ_BERR    1
`define IRQ_ARB     2
// status codes
`define SC_NONE     8'hF8
`define SC_BERR     8'h00
`define SC_START    8'h08
`define SC_RSTART   8'h10
`define SC_MT_SAK   8'h18
`define SC_MT_SNAK  8'h20
`define SC_MT_DAK   8'h28
`define SC_MT_DNAK  8'h30
`define SC_ARB      8'h38
`define SC_MR_SAK   8'h40
`define SC_MR_SNAK  8'h48
`define SC_MR_DAK   8'h50
`define SC_MR_DNAK  8'h58
`define SC_SR_SLA   8'h60
`define SC_SR_ARB   8'h68
`define SC_SR_DAK   8'h80
`define SC_SR_DNAK  8'h88
`define SC_SR_STOP  8'hA0
`define SC_ST_SLA   8'hA8
`define SC_ST_ARB   8'hB0
`define SC_ST_DAK   8'hB8
`define SC_ST_DNAK  8'hC0
// bit timing and counts
`define BR_BASE     16'h0008
`define BITS_DATA   4'h8
`define BIT_NONE    4'h0
`define GC_ADDR     7'h00
`endif

// File: logic/bus_cond_detect.v
// pin synchroniser with clock edge and start/stop condition detection
`default_nettype none
module bus_cond_detect (
  input  wire core_clk,
  input  wire rst_n,
  input  wire ce,
  input  wire scl_pin,
  input  wire sda_pin,
  output reg  scl_s,
  output reg  sda_s,
  output reg  scl_rise,
  output reg  scl_fall,
  output reg  start_det,
  output reg  stop_det
);
  reg scl_meta;
  reg scl_sync;
  reg sda_meta;
  reg sda_sync;

  // two-stage sync, third stage gives the previous level for edges
  always @(posedge core_clk) begin
    if (!rst_n) begin
      scl_meta  <= 1'b1;
      scl_sync  <= 1'b1;
      sda_meta  <= 1'b1;
      sda_sync  <= 1'b1;
      scl_s     <= 1'b1;
      sda_s     <= 1'b1;
      scl_rise  <= 1'b0;
      scl_fall  <= 1'b0;
      start_det <= 1'b0;
      stop_det  <= 1'b0;
    end else if (ce) begin
      scl_meta  <= scl_pin;
      scl_sync  <= scl_meta;
      sda_meta  <= sda_pin;
      sda_sync  <= sda_meta;
      scl_s     <= scl_sync;
      sda_s     <= sda_sync;
      scl_rise  <= scl_sync & ~scl_s;
      scl_fall  <= ~scl_sync & scl_s;
      start_det <= scl_sync & scl_s & sda_s & ~sda_sync; // sda falls, scl high
      stop_det  <= scl_sync & scl_s & ~sda_s & sda_sync; // sda rises, scl high
    end
  end
endmodule
`default_nettype wire

// File: logic/two_wire_error_arbitration_ctl.v
// two-wire controller core: status, bus error recovery, arbitration, bit rate
//
// The AHB-Lite register port was left to the implementer.
`default_nettype none
`include "two_wire_consts.vh"
// Overview of operation
// - status reads F8 while job-done is clear
// - at F8 hardware waits or continues transfer
// - misplaced start or stop gives status 00
// - bus error sets the job-done flag
// - stop request plus clear recovers, clears stop
// - recovery releases lines, sends no stop
// - direction change uses a repeated start
// - master keeps bus after repeated start
// - driving one but seeing zero loses arbitration
// - identical transfers flag no arbitration loss
// - data loss: idle slave or restart later
// - address loss: compare own address, become slave
// - address loss without match: idle or restart
// - divisor register at 70, reset 00
// - divisor sets serial clock division in master
// - job-done set stretches serial clock low, except after a bus error (status 00)
// - status code in bits seven to three
module two_wire_error_arbitration_ctl (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         irq
);
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_START = 4'h1;
  localparam [3:0] S_BYTE  = 4'h2;
  localparam [3:0] S_HOLD  = 4'h3;
  localparam [3:0] S_RS1   = 4'h4;
  localparam [3:0] S_RS2   = 4'h5;
  localparam [3:0] S_SP1   = 4'h6;
  localparam [3:0] S_SP2   = 4'h7;
  localparam [3:0] S_SP3   = 4'h8;

  // half serial clock period in system clocks
  function [15:0] half_period;
    input [7:0] div;
    input [1:0] ps;
    begin
      half_period = `BR_BASE + ({8'h00, div} << {ps, 1'b0});
    end
  endfunction

  // software-visible registers
  reg [7:0]  bit_rate_divisor_reg;
  reg [1:0]  ps_reg;
  reg [7:0]  own_addr_reg;
  reg [7:0]  byte_shift_reg;
  reg [7:0]  code_reg;
  reg        job_done_flag_reg;
  reg        ack_enable_bit_reg;
  reg        start_req_reg;
  reg        stop_request_bit_reg;
  reg        wr_coll_reg;
  reg        enable_reg;
  reg        int_en_reg;
  reg [2:0]  irq_st_reg;
  reg [2:0]  irq_mask_reg;
  // bus slave state
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [9:0]  wr_idx_reg;
  reg [9:0]  rd_idx_reg;
  // engine state
  reg [3:0]  state_reg;
  reg [15:0] tim_reg;
  reg [3:0]  bit_cnt_reg;
  reg        master_reg;
  reg        tx_reg;
  reg        is_addr_reg;
  reg        lost_reg;
  reg        slv_reg;
  reg        end_reg;
  reg        rs_reg;
  reg        busy_reg;
  reg        ack_in_reg;
  reg        jd_d_reg;
  reg        lost_d_reg;

  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire [15:0] half_m1;
  wire        tick;
  wire        run;
  wire        adr_hit;
  wire [7:0]  sts_code;
  wire [2:0]  ist_clr;
  wire [2:0]  irq_ev;
  reg  [7:0]  rd_data;

  // pin synchronisers and condition detectors
  bus_cond_detect u_det (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .scl_pin   (scl_in),
    .sda_pin   (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // bit timer: runs while scl is low by us or seen high
  assign half_m1 = half_period(bit_rate_divisor_reg, ps_reg) - 16'h0001;
  assign tick    = (tim_reg == half_m1);
  assign run     = scl_oe | scl_s;
  // own address or enabled general call
  assign adr_hit = (byte_shift_reg[7:1] == own_addr_reg[7:1]) |
                   (own_addr_reg[0] & (byte_shift_reg[7:1] == `GC_ADDR));
  assign sts_code = job_done_flag_reg ? code_reg : `SC_NONE;
  // write-one-to-clear mask and interrupt events
  assign ist_clr = (wr_pend_reg && wr_idx_reg == `IDX_IST) ? hwdata[`IRQ_BITS] : 3'h0;
  assign irq_ev[`IRQ_JD]   = job_done_flag_reg & ~jd_d_reg;
  assign irq_ev[`IRQ_BERR] = job_done_flag_reg & ~jd_d_reg & (code_reg == `SC_BERR);
  assign irq_ev[`IRQ_ARB]  = lost_reg & ~lost_d_reg;

  // register read mux
  always @* begin
    case (rd_idx_reg)
      `IDX_BRD: rd_data = bit_rate_divisor_reg;
      `IDX_STS: rd_data = {sts_code[`STS_CODE], 1'b0, ps_reg};
      `IDX_ADR: rd_data = own_addr_reg;
      `IDX_DAT: rd_data = byte_shift_reg;
      `IDX_CTL: rd_data = {job_done_flag_reg, ack_enable_bit_reg, start_req_reg,
                           stop_request_bit_reg, wr_coll_reg, enable_reg, 1'b0, int_en_reg};
      `IDX_IST: rd_data = {5'h00, irq_st_reg};
      `IDX_IMK: rd_data = {5'h00, irq_mask_reg};
      default:  rd_data = 8'h00;
    endcase
  end

  // bus slave, registers, transfer engine and interrupt in one process
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata               <= 32'h00000000;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      scl_out              <= 1'b0;
      sda_out              <= 1'b0;
      scl_oe               <= 1'b0;
      sda_oe               <= 1'b0;
      irq                  <= 1'b0;
      bit_rate_divisor_reg <= `RST_BRD;
      ps_reg               <= 2'h0;
      own_addr_reg         <= `RST_ADR;
      byte_shift_reg       <= `RST_DAT;
      code_reg             <= `SC_NONE;
      job_done_flag_reg    <= 1'b0;
      ack_enable_bit_reg   <= 1'b0;
      start_req_reg        <= 1'b0;
      stop_request_bit_reg <= 1'b0;
      wr_coll_reg          <= 1'b0;
      enable_reg           <= 1'b0;
      int_en_reg           <= 1'b0;
      irq_st_reg           <= 3'h0;
      irq_mask_reg         <= 3'h0;
      wr_pend_reg          <= 1'b0;
      rd_pend_reg          <= 1'b0;
      wr_idx_reg           <= 10'h000;
      rd_idx_reg           <= 10'h000;
      state_reg            <= S_IDLE;
      tim_reg              <= 16'h0000;
      bit_cnt_reg          <= `BIT_NONE;
      master_reg           <= 1'b0;
      tx_reg               <= 1'b0;
      is_addr_reg          <= 1'b0;
      lost_reg             <= 1'b0;
      slv_reg              <= 1'b0;
      end_reg              <= 1'b0;
      rs_reg               <= 1'b0;
      busy_reg             <= 1'b0;
      ack_in_reg           <= 1'b0;
      jd_d_reg             <= 1'b0;
      lost_d_reg           <= 1'b0;
    end else if (ce) begin
      // address phase: writes zero-wait, reads one wait state
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      scl_out     <= 1'b0;
      sda_out     <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      if (rd_pend_reg) begin
        hrdata <= {24'h000000, rd_data};
      end
      if (hsel && hready && htrans[1] && hsize == `HSIZE_WORD) begin
        if (hwrite) begin
          wr_pend_reg <= 1'b1;
          wr_idx_reg  <= haddr[`IDX_RANGE];
        end else begin
          rd_pend_reg <= 1'b1;
          rd_idx_reg  <= haddr[`IDX_RANGE];
          hreadyout   <= 1'b0;
        end
      end
      // data phase of a write
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `IDX_BRD: bit_rate_divisor_reg <= hwdata[7:0];
          `IDX_STS: ps_reg <= hwdata[`STS_PS];
          `IDX_ADR: own_addr_reg <= hwdata[7:0];
          `IDX_DAT: begin
            if (job_done_flag_reg) begin
              byte_shift_reg <= hwdata[7:0];
              wr_coll_reg    <= 1'b0;
            end else begin
              wr_coll_reg <= 1'b1;
            end
          end
          `IDX_CTL: begin
            ack_enable_bit_reg   <= hwdata[`C_EA];
            start_req_reg        <= hwdata[`C_STA];
            stop_request_bit_reg <= hwdata[`C_STO];
            enable_reg           <= hwdata[`C_EN];
            int_en_reg           <= hwdata[`C_IE];
            if (hwdata[`C_JD]) begin
              job_done_flag_reg <= 1'b0;
            end
          end
          `IDX_IMK: irq_mask_reg <= hwdata[`IRQ_BITS];
          default: ;
        endcase
      end
      // transfer engine; its assignments come later so they win over a register write
      if (!enable_reg) begin
        state_reg  <= S_IDLE;
        scl_oe     <= 1'b0;
        sda_oe     <= 1'b0;
        master_reg <= 1'b0;
        busy_reg   <= 1'b0;
        tim_reg    <= 16'h0000;
      end else begin
        if (start_det) begin
          busy_reg <= 1'b1;
        end
        if (stop_det) begin
          busy_reg <= 1'b0;
        end
        tim_reg <= (run && !tick) ? tim_reg + 16'h0001 : 16'h0000;
        case (state_reg)
          S_IDLE: begin
            tim_reg    <= 16'h0000;
            scl_oe     <= 1'b0;
            sda_oe     <= 1'b0;
            master_reg <= 1'b0;
            if (start_det) begin
              state_reg   <= S_BYTE;
              bit_cnt_reg <= `BIT_NONE;
              is_addr_reg <= 1'b1;
              tx_reg      <= 1'b0;
              lost_reg    <= 1'b0;
              slv_reg     <= 1'b0;
              end_reg     <= 1'b0;
            end else if (start_req_reg && !busy_reg && !job_done_flag_reg) begin
              state_reg <= S_START;
              rs_reg    <= 1'b0;
              sda_oe    <= 1'b1;
            end
          end
          S_START: begin
            if (tick) begin
              scl_oe            <= 1'b1;
              job_done_flag_reg <= 1'b1;
              code_reg          <= rs_reg ? `SC_RSTART : `SC_START;
              master_reg        <= 1'b1;
              tx_reg            <= 1'b1;
              is_addr_reg       <= 1'b1;
              lost_reg          <= 1'b0;
              end_reg           <= 1'b0;
              state_reg         <= S_HOLD;
            end
          end
          S_HOLD: begin
            tim_reg <= 16'h0000;
            scl_oe  <= (code_reg != `SC_BERR);
            if (!job_done_flag_reg) begin
              if (code_reg == `SC_BERR || (!master_reg && stop_request_bit_reg)) begin
                stop_request_bit_reg <= 1'b0;
                state_reg            <= S_IDLE;
                scl_oe               <= 1'b0;
                sda_oe               <= 1'b0;
                slv_reg              <= 1'b0;
              end else if (master_reg && start_req_reg) begin
                rs_reg    <= 1'b1;
                state_reg <= S_RS1;
                sda_oe    <= 1'b0;
              end else if (master_reg && stop_request_bit_reg) begin
                state_reg <= S_SP1;
                sda_oe    <= 1'b1;
              end else if (end_reg) begin
                state_reg <= S_IDLE;
                slv_reg   <= 1'b0;
                scl_oe    <= 1'b0;
              end else begin
                state_reg   <= S_BYTE;
                bit_cnt_reg <= `BIT_NONE;
                scl_oe      <= master_reg;
                sda_oe      <= tx_reg & ~byte_shift_reg[7];
              end
            end
          end
          S_BYTE: begin
            if ((start_det || stop_det) && bit_cnt_reg != `BIT_NONE) begin
              code_reg          <= `SC_BERR;
              job_done_flag_reg <= 1'b1;
              state_reg         <= S_HOLD;
              scl_oe            <= 1'b0;
              sda_oe            <= 1'b0;
              master_reg        <= 1'b0;
              slv_reg           <= 1'b0;
              end_reg           <= 1'b0;
            end else if (start_det && !master_reg) begin
              is_addr_reg <= 1'b1;
              tx_reg      <= 1'b0;
              sda_oe      <= 1'b0;
              slv_reg     <= 1'b0;
              lost_reg    <= 1'b0;
            end else if (stop_det && !master_reg) begin
              sda_oe <= 1'b0;
              if (slv_reg) begin
                code_reg          <= `SC_SR_STOP;
                job_done_flag_reg <= 1'b1;
                end_reg           <= 1'b1;
                state_reg         <= S_HOLD;
              end else begin
                state_reg <= S_IDLE;
              end
            end else begin
              // serial clock generation while master
              if (master_reg && tick) begin
                scl_oe <= ~scl_oe;
              end
              // sample on rising edge, shift in what the bus carries
              if (scl_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg < `BITS_DATA) begin
                  byte_shift_reg <= {byte_shift_reg[6:0], sda_s};
                  if (master_reg && tx_reg && !sda_oe && !sda_s) begin
                    lost_reg   <= 1'b1;
                    master_reg <= 1'b0;
                    tx_reg     <= 1'b0;
                  end
                end else begin
                  ack_in_reg <= ~sda_s;
                end
              end
              // drive on falling edge
              if (scl_fall) begin
                if (bit_cnt_reg < `BITS_DATA) begin
                  sda_oe <= tx_reg & ~byte_shift_reg[7];
                end else if (bit_cnt_reg == `BITS_DATA) begin
                  if (is_addr_reg && !master_reg) begin
                    sda_oe <= adr_hit & ack_enable_bit_reg;
                    if (!(adr_hit && ack_enable_bit_reg) && !lost_reg) begin
                      state_reg <= S_IDLE;
                    end
                  end else begin
                    sda_oe <= ~tx_reg & ~is_addr_reg & ~lost_reg & ack_enable_bit_reg;
                  end
                end else begin
                  // byte and acknowledge complete
                  job_done_flag_reg <= 1'b1;
                  state_reg         <= S_HOLD;
                  bit_cnt_reg       <= `BIT_NONE;
                  is_addr_reg       <= 1'b0;
                  sda_oe            <= 1'b0;
                  lost_reg          <= 1'b0;
                  if (master_reg) begin
                    if (is_addr_reg) begin
                      tx_reg   <= ~byte_shift_reg[0];
                      code_reg <= byte_shift_reg[0] ?
                                  (ack_in_reg ? `SC_MR_SAK : `SC_MR_SNAK) :
                                  (ack_in_reg ? `SC_MT_SAK : `SC_MT_SNAK);
                    end else if (tx_reg) begin
                      code_reg <= ack_in_reg ? `SC_MT_DAK : `SC_MT_DNAK;
                    end else begin
                      code_reg <= ack_in_reg ? `SC_MR_DAK : `SC_MR_DNAK;
                    end
                  end else if (is_addr_reg && adr_hit && ack_enable_bit_reg) begin
                    slv_reg  <= 1'b1;
                    tx_reg   <= byte_shift_reg[0];
                    end_reg  <= 1'b0;
                    code_reg <= byte_shift_reg[0] ?
                                (lost_reg ? `SC_ST_ARB : `SC_ST_SLA) :
                                (lost_reg ? `SC_SR_ARB : `SC_SR_SLA);
                  end else if (lost_reg) begin
                    code_reg <= `SC_ARB;
                    end_reg  <= 1'b1;
                  end else if (tx_reg) begin
                    code_reg <= ack_in_reg ? `SC_ST_DAK : `SC_ST_DNAK;
                    end_reg  <= ~ack_in_reg;
                  end else begin
                    code_reg <= ack_in_reg ? `SC_SR_DAK : `SC_SR_DNAK;
                    end_reg  <= ~ack_in_reg;
                  end
                end
              end
            end
          end
          // repeated start: release sda while low, raise scl, then start
          S_RS1: begin
            if (tick) begin
              scl_oe    <= 1'b0;
              state_reg <= S_RS2;
            end
          end
          S_RS2: begin
            if (tick) begin
              sda_oe    <= 1'b1;
              state_reg <= S_START;
            end
          end
          // stop: sda low, raise scl, then raise sda
          S_SP1: begin
            if (tick) begin
              scl_oe    <= 1'b0;
              state_reg <= S_SP2;
            end
          end
          S_SP2: begin
            if (tick) begin
              sda_oe    <= 1'b0;
              state_reg <= S_SP3;
            end
          end
          S_SP3: begin
            if (tick) begin
              stop_request_bit_reg <= 1'b0;
              master_reg           <= 1'b0;
              state_reg            <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
      // sticky interrupt status, set beats write-one clear
      jd_d_reg   <= job_done_flag_reg;
      lost_d_reg <= lost_reg;
      irq_st_reg <= (irq_st_reg & ~ist_clr) | irq_ev;
      irq        <= |(irq_st_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// File: tb/two_wire_bus_model.sv
// far-side bus party: pull-ups, stray frames and a competing master
`default_nettype none
module two_wire_bus_model (
  input  wire logic core_clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  int   stops   = 0;
  // open-drain lines with pull-ups
  assign scl = ~(scl_oe | scl_low);
  assign sda = ~(sda_oe | sda_low);
  // stop conditions seen on the wire
  always @(posedge sda) if (scl) stops <= stops + 1;
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // clock pulses, 20 cycles low then 20 high
  task automatic pulses(input int n);
    repeat (n) begin
      scl_low <= 1'b1;
      hold(20);
      scl_low <= 1'b0;
      hold(20);
    end
  endtask
  // start, two bits, then a stop inside the byte
  task automatic bad_frame();
    sda_low <= 1'b1;
    hold(20);
    pulses(2);
    sda_low <= 1'b0;
    hold(20);
  endtask
  // pull data low against the device, then clock out the byte
  task automatic contend();
    sda_low <= 1'b1;
    wait (scl_oe === 1'b0);
    hold(20);
    pulses(8);
    // final falling edge closes the ack slot, then release data while scl is low
    scl_low <= 1'b1;
    hold(20);
    sda_low <= 1'b0;
    hold(20);
    scl_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/two_wire_ctl_assertions.sv
// port checks for the two-wire controller
`default_nettype none
`include "two_wire_consts.vh"
module two_wire_ctl_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire       tk  = hsel && hready && htrans[1] && hsize == `HSIZE_WORD;
  wire [9:0] idx = haddr[`IDX_RANGE];
  logic       wpend;
  logic [7:0] div_sh;
  // shadow of the last divisor write
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wpend  <= 1'b0;
      div_sh <= `RST_BRD;
    end else begin
      wpend <= tk && hwrite && idx == `IDX_BRD;
      if (wpend) div_sh <= hwdata[7:0];
    end
  end
  chk_resp_okay: assert property (!hresp) else $error("error response seen");
  chk_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  chk_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  chk_reset_quiet: assert property ($rose(rst_n) |-> hreadyout && !irq && !scl_oe && !sda_oe)
    else $error("outputs not quiet after reset");
  chk_status_form: assert property (tk && !hwrite && idx == `IDX_STS |->
    ##2 hrdata[31:8] == 24'h0 && !hrdata[2]) else $error("status layout wrong");
  chk_divisor_rw: assert property (tk && !hwrite && idx == `IDX_BRD |->
    ##2 hrdata[7:0] == div_sh) else $error("divisor readback wrong");
  chk_unmapped_zero: assert property (tk && !hwrite && (idx < `IDX_BRD || idx > `IDX_IMK)
    |-> ##2 hrdata == 32'h0) else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  cover property (tk && !hwrite && idx == `IDX_STS);
  cover property ($rose(irq));
  cover property ($rose(scl_oe));
endmodule
bind two_wire_error_arbitration_ctl two_wire_ctl_checker chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// File: tb/two_wire_error_arbitration_ctl_test.sv
// bench: registers, bus error and recovery, restart, arbitration loss
`default_nettype none
`include "two_wire_consts.vh"
module two_wire_error_arbitration_ctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] BRD = {`IDX_BRD, 2'h0};
  localparam logic [11:0] STS = {`IDX_STS, 2'h0};
  localparam logic [11:0] DAT = {`IDX_DAT, 2'h0};
  localparam logic [11:0] CTL = {`IDX_CTL, 2'h0};
  localparam logic [11:0] IST = {`IDX_IST, 2'h0};
  localparam logic [11:0] IMK = {`IDX_IMK, 2'h0};
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] rdat;
  wire  [31:0] hrdata;
  wire         hready, hresp, scl, sda, scl_oe, sda_oe, irq;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          stops0;
  two_wire_error_arbitration_ctl dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .irq(irq));
  two_wire_bus_model bus (
    .core_clk(core_clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    xfer(1'b0, a, 8'h00);
    chk(n, e, rdat[7:0]);
  endtask
  // poll control until the job-done flag shows
  task automatic wait_jd();
    rdat = 32'h0;
    for (int i = 0; i < 600 && rdat[7] !== 1'b1; i++) xfer(1'b0, CTL, 8'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #(50 * 30000);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(BRD, `RST_BRD, "divisor");
    rd(STS, `SC_NONE, "status");
    rd(CTL, 8'h00, "control");
    xfer(1'b1, BRD, 8'hA5);
    rd(BRD, 8'hA5, "divisor");
    rd(12'hFFC, 8'h00, "unmapped");
    xfer(1'b1, BRD, 8'h01);
    xfer(1'b1, CTL, 8'h04);
    bus.bad_frame();
    wait_jd();
    rd(STS, `SC_BERR, "status");
    rd(CTL, 8'h84, "control");
    chk("line drive", 8'h00, {6'h0, scl_oe, sda_oe});
    rd(IST, 8'h03, "irq status");
    chk("irq masked", 8'h00, {7'h0, irq});
    xfer(1'b1, IMK, 8'h07);
    repeat (2) @(posedge core_clk);
    chk("irq", 8'h01, {7'h0, irq});
    xfer(1'b1, IST, 8'h07);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    stops0 = bus.stops;
    xfer(1'b1, CTL, 8'hD4);
    rd(CTL, 8'h44, "control");
    rd(STS, `SC_NONE, "status");
    chk("stop count", stops0[7:0], bus.stops[7:0]);
    xfer(1'b1, CTL, 8'h24);
    wait_jd();
    rd(STS, `SC_START, "status");
    chk("scl stretch", 8'h01, {7'h0, scl_oe});
    xfer(1'b1, CTL, 8'hA4);
    wait_jd();
    rd(STS, `SC_RSTART, "status");
    chk("stop count", stops0[7:0], bus.stops[7:0]);
    xfer(1'b1, DAT, 8'hFE);
    fork
      bus.contend();
      xfer(1'b1, CTL, 8'h84);
    join
    wait_jd();
    rd(STS, `SC_ARB, "status");
    rd(IST, 8'h05, "irq status");
    end_sim();
  end
endmodule
`default_nettype wire
